// ===== design/slpc_params.svh
`ifndef SLPC_PARAMS_SVH
`define SLPC_PARAMS_SVH
// What this block does
// - Oscillator enable is bit 8 for RC-trimmed, bit 9 for crystal.
// - Either enable bit set means reference enabled; both clear means off.
// - Reference on, idle bit clear: PLL regulates to the 32 kHz reference.
// - Sleep entry never changes the reference oscillator state.
// - Idle bit clear: PLL and master clock run in sleep if reference on.
// - Idle bit set: master, CPU, timer clocks stop except reference timers.
// - Idle clock-control bit is bit 10 of clock speed control, index 0x3d.
// - Arm bit 14 of index 0x38 gives asynchronous wake response in sleep.
// - Idle set and arm clear: only hardware reset ends sleep.
// - CPU clock stops in sleep; master clock runs only light, PLL whenever idle is clear.
// - Half-master timers run light only; reference timers light and mid.
// - Core held until reference oscillator restart delay has elapsed.
// - Sleep stops CPU, PLL and master clock if idle set, else CPU, plus master clock if reference off.
// - Reset always ends sleep at once, resuming at the reset vector.

// Register indices; byte address is four times the index
`define SLPC_IDX_DAC 8'h34
`define SLPC_IDX_IGC 8'h38
`define SLPC_IDX_CSC 8'h3d
`define SLPC_IDX_IRQ_STS 8'h40
`define SLPC_IDX_IRQ_MSK 8'h41
`define SLPC_IDX_STATE 8'h42

// Field positions
`define SLPC_CSC_MULT_LSB 0
`define SLPC_CSC_MULT_MSB 7
`define SLPC_CSC_RTO_EN_BIT 8
`define SLPC_CSC_CRO_EN_BIT 9
`define SLPC_CSC_IDLE_BIT 10
`define SLPC_IGC_ARM_BIT 14
`define SLPC_DAC_PDM_BIT 2
`define SLPC_IRQ_WAKE_BIT 0
`define SLPC_IRQ_OSC_RDY_BIT 1
`define SLPC_IRQ_SLEEP_BIT 2
`define SLPC_IRQ_W 3

// Reset values
`define SLPC_DAC_RST 16'h0000
`define SLPC_IGC_RST 16'h0000
`define SLPC_CSC_RST 16'h0000
`define SLPC_IRQ_RST 3'h0

// Timing
`define SLPC_CLK_PERIOD_NS 100
`define SLPC_RTO_START_NS 1000000
`define SLPC_CRO_START_NS 10000000
`endif

// ===== design/slpc_pkg.sv
`default_nettype none
package slpc_pkg;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_SLEEP,
      ST_RESTART
   } slpc_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } slpc_apb_req_s;

   typedef struct packed {
      logic cpu;
      logic pll;
      logic pll_ref;
      logic mclk;
      logic ref_osc;
      logic rc_trimmed_oscillator;
      logic crystal_reference_oscillator;
      logic pdm;
      logic [1:0] timer;
   } slpc_clk_en_s;

endpackage : slpc_pkg
`default_nettype wire

// ===== design/slpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module slpc_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   import slpc_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } slpc_sync_st_s;

   slpc_sync_st_s state_reg, state_next;

   if (W < 1) begin : g_chk
      $error("slpc_sync: width must be at least one");
   end

   always_comb begin
      state_next.s1 = d_i;
      state_next.s2 = state_reg.s1;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign q_o = state_reg.s2;

   a_sync_two_stage: assert property (@(posedge clk_sys_i)
      disable iff (sys_rst_i)
      (!$past(sys_rst_i) && !$past(sys_rst_i, 2)) |-> q_o == $past(d_i, 2))
      else $error("synchroniser output is not input delayed by two");

endmodule : slpc_sync
`default_nettype wire

// ===== design/slpc_delay.sv
`timescale 1ns/1ps
`default_nettype none
module slpc_delay #(
   parameter int CNT_W = 17
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic load_i,
   input wire logic [CNT_W-1:0] count_i,
   output logic busy_o
);
   import slpc_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } slpc_dly_st_s;

   slpc_dly_st_s state_reg, state_next;

   if (CNT_W < 2) begin : g_chk
      $error("slpc_delay: counter too narrow");
   end

   // A reload restarts the wait from count_i, even if that is shorter than what remains
   always_comb begin
      state_next = state_reg;
      if (load_i) begin
         state_next.cnt = count_i;
      end else if (state_reg.cnt != '0) begin
         state_next.cnt = state_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign busy_o = (state_reg.cnt != '0);

   a_dly_load: assert property (@(posedge clk_sys_i)
      disable iff (sys_rst_i) load_i |=> state_reg.cnt == $past(count_i))
      else $error("restart delay not loaded");

   a_dly_count: assert property (@(posedge clk_sys_i)
      disable iff (sys_rst_i)
      (busy_o && !load_i) |=> state_reg.cnt == $past(state_reg.cnt) - 1'b1)
      else $error("restart delay does not count down by one");

endmodule : slpc_delay
`default_nettype wire

// ===== design/slpc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "slpc_params.svh"
module slpc_top #(
   parameter int PORT_W = 12,
   parameter int CNT_W = 17,
   parameter int RTO_START_CYC =
      (`SLPC_RTO_START_NS + `SLPC_CLK_PERIOD_NS - 1) / `SLPC_CLK_PERIOD_NS,
   parameter int CRO_START_CYC =
      (`SLPC_CRO_START_NS + `SLPC_CLK_PERIOD_NS - 1) / `SLPC_CLK_PERIOD_NS
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire slpc_pkg::slpc_apb_req_s apb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sleep_req_i,
   input wire logic osc_crystal_i,
   input wire logic [1:0] timer_en_i,
   input wire logic [1:0] timer_src_ref_i,
   input wire logic [1:0] timer_uf_i,
   input wire logic [PORT_W-1:0] port_evt_i,
   output slpc_pkg::slpc_clk_en_s clk_en_o,
   output logic [7:0] pll_mult_o,
   output logic async_resp_o,
   output logic core_hold_o,
   output logic sleeping_o,
   output logic [PORT_W+1:0] wake_src_o,
   output logic wake_pulse_o,
   output logic irq_o
);
   import slpc_pkg::*;

   localparam int EVT_W = PORT_W + 2;

   typedef struct packed {
      slpc_state_e st;
      logic [15:0] dac_output_control;
      logic [15:0] interrupt_general_control;
      logic [15:0] clock_speed_control;
      logic [`SLPC_IRQ_W-1:0] irq_status;
      logic [`SLPC_IRQ_W-1:0] irq_mask;
      logic ref_prev;
      logic busy_prev;
      logic [EVT_W-1:0] wake_src;
      logic wake_pulse;
   } slpc_top_st_s;

   slpc_top_st_s state_reg, state_next;

   // ****************************************************
   // Parameter checks
   // ****************************************************
   if (PORT_W < 1 || CNT_W < 2 || RTO_START_CYC < 1 ||
       CRO_START_CYC < 1 || CRO_START_CYC >= (1 << CNT_W) ||
       RTO_START_CYC >= (1 << CNT_W)) begin : g_chk
      $error("slpc_top: parameters out of range");
   end

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [EVT_W-1:0] evt_s;
   logic xtal_s;
   logic dly_busy;

   // Wake sources may toggle while every clock here is slow or stopped
   slpc_sync #(.W(EVT_W)) u_evt_sync (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .d_i({timer_uf_i, port_evt_i}),
      .q_o(evt_s)
   );

   slpc_sync #(.W(1)) u_xtal_sync (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .d_i(osc_crystal_i),
      .q_o(xtal_s)
   );

   // ****************************************************
   // Mode decode
   // ****************************************************
   logic idle, rto_bit, cro_bit, ref_en, arm, sleeping;
   logic pll_run, mclk_run, wake_ok, need_dly, dly_load;
   logic [1:0] timer_run;
   logic [EVT_W-1:0] evt_ok;
   logic [CNT_W-1:0] dly_count;

   assign idle = state_reg.clock_speed_control[`SLPC_CSC_IDLE_BIT];
   assign rto_bit = state_reg.clock_speed_control[`SLPC_CSC_RTO_EN_BIT];
   assign cro_bit = state_reg.clock_speed_control[`SLPC_CSC_CRO_EN_BIT];
   assign ref_en = rto_bit | cro_bit;
   assign arm = state_reg.interrupt_general_control[`SLPC_IGC_ARM_BIT];
   assign sleeping = (state_reg.st == ST_SLEEP);

   assign pll_run = sleeping ? ~idle : 1'b1;
   assign mclk_run = sleeping ? (~idle & ref_en) : 1'b1;

   // Reference timers follow the oscillator, others the master clock
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         timer_run[i] = timer_en_i[i] &
            (timer_src_ref_i[i] ? ref_en : mclk_run);
      end
   end

   // A stopped timer cannot underflow, so its event is not a wake source
   assign evt_ok = evt_s & {timer_run, {PORT_W{1'b1}}};
   // Synchronous path needs the master clock; armed path needs nothing
   assign wake_ok = sleeping & (|evt_ok) &
      (arm | (~idle & ref_en));
   assign need_dly = idle | ~ref_en;
   assign dly_load = (ref_en & ~state_reg.ref_prev) |
      (wake_ok & need_dly);
   assign dly_count = xtal_s ? CNT_W'(CRO_START_CYC) :
      CNT_W'(RTO_START_CYC);

   slpc_delay #(.CNT_W(CNT_W)) u_delay (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .load_i(dly_load),
      .count_i(dly_count),
      .busy_o(dly_busy)
   );

   // ****************************************************
   // APB decode
   // ****************************************************
   logic acc, wr, hit;
   logic [7:0] idx;
   logic [`SLPC_IRQ_W-1:0] irq_set, irq_clr;

   assign acc = apb_i.psel & apb_i.penable;
   assign wr = acc & apb_i.pwrite;
   assign idx = apb_i.paddr[9:2];

   always_comb begin
      hit = 1'b1;
      prdata_o = 32'h0000_0000;
      case (idx)
         `SLPC_IDX_DAC: begin
            prdata_o = {16'h0000, state_reg.dac_output_control};
         end
         `SLPC_IDX_IGC: begin
            prdata_o = {16'h0000, state_reg.interrupt_general_control};
         end
         `SLPC_IDX_CSC: begin
            prdata_o = {16'h0000, state_reg.clock_speed_control};
         end
         `SLPC_IDX_IRQ_STS: begin
            prdata_o = {29'h0000_0000, state_reg.irq_status};
         end
         `SLPC_IDX_IRQ_MSK: begin
            prdata_o = {29'h0000_0000, state_reg.irq_mask};
         end
         `SLPC_IDX_STATE: begin
            prdata_o = {27'h0000_0000, ref_en, xtal_s, dly_busy,
               state_reg.st};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      if (apb_i.paddr[11:10] != 2'h0 || apb_i.paddr[1:0] != 2'h0) begin
         hit = 1'b0;
         prdata_o = 32'h0000_0000;
      end
   end

   // Zero wait states: every access completes in its first access cycle
   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~hit;

   assign irq_clr = (wr && hit && idx == `SLPC_IDX_IRQ_STS) ?
      apb_i.pwdata[`SLPC_IRQ_W-1:0] : '0;

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      state_next = state_reg;
      state_next.wake_pulse = 1'b0;
      state_next.ref_prev = ref_en;
      state_next.busy_prev = dly_busy;
      irq_set = '0;
      if (wr && hit) begin
         case (idx)
            `SLPC_IDX_DAC: begin
               state_next.dac_output_control = apb_i.pwdata[15:0];
            end
            `SLPC_IDX_IGC: begin
               state_next.interrupt_general_control = apb_i.pwdata[15:0];
            end
            `SLPC_IDX_CSC: begin
               state_next.clock_speed_control = apb_i.pwdata[15:0];
            end
            `SLPC_IDX_IRQ_MSK: begin
               state_next.irq_mask = apb_i.pwdata[`SLPC_IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      case (state_reg.st)
         ST_RUN: begin
            if (sleep_req_i) begin
               state_next.st = ST_SLEEP;
               irq_set[`SLPC_IRQ_SLEEP_BIT] = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (wake_ok) begin
               state_next.wake_src = evt_ok;
               if (need_dly) begin
                  state_next.st = ST_RESTART;
               end else begin
                  state_next.st = ST_RUN;
                  state_next.wake_pulse = 1'b1;
                  irq_set[`SLPC_IRQ_WAKE_BIT] = 1'b1;
               end
            end
         end
         ST_RESTART: begin
            // Counter starts the cycle after the load, so wait for it
            if (!dly_busy && state_reg.busy_prev) begin
               state_next.st = ST_RUN;
               state_next.wake_pulse = 1'b1;
               irq_set[`SLPC_IRQ_WAKE_BIT] = 1'b1;
            end
         end
         default: begin
            state_next.st = ST_RUN;
         end
      endcase
      irq_set[`SLPC_IRQ_OSC_RDY_BIT] = state_reg.busy_prev & ~dly_busy;
      // Set beats a clear in the same cycle
      state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_reg.st <= ST_RUN;
         state_reg.dac_output_control <= `SLPC_DAC_RST;
         state_reg.interrupt_general_control <= `SLPC_IGC_RST;
         state_reg.clock_speed_control <= `SLPC_CSC_RST;
         state_reg.irq_status <= `SLPC_IRQ_RST;
         state_reg.irq_mask <= `SLPC_IRQ_RST;
         state_reg.ref_prev <= 1'b0;
         state_reg.busy_prev <= 1'b0;
         state_reg.wake_src <= '0;
         state_reg.wake_pulse <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign clk_en_o.cpu = (state_reg.st == ST_RUN) & ~dly_busy;
   assign clk_en_o.pll = pll_run;
   assign clk_en_o.pll_ref = ref_en & ~idle;
   assign clk_en_o.mclk = mclk_run;
   // Oscillator enable ignores the sleep state entirely
   assign clk_en_o.ref_osc = ref_en;
   assign clk_en_o.rc_trimmed_oscillator = ~xtal_s & rto_bit;
   assign clk_en_o.crystal_reference_oscillator = xtal_s & cro_bit;
   assign clk_en_o.pdm =
      state_reg.dac_output_control[`SLPC_DAC_PDM_BIT] & ~sleeping;
   assign clk_en_o.timer = timer_run;
   assign pll_mult_o =
      state_reg.clock_speed_control[`SLPC_CSC_MULT_MSB:`SLPC_CSC_MULT_LSB];
   assign async_resp_o = sleeping & arm;
   assign core_hold_o = (state_reg.st != ST_RUN) | dly_busy;
   assign sleeping_o = sleeping;
   assign wake_src_o = state_reg.wake_src;
   assign wake_pulse_o = state_reg.wake_pulse;
   assign irq_o = |(state_reg.irq_status & state_reg.irq_mask);

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_enter_sleep;
      state_reg.st == ST_RUN && sleep_req_i;
   endsequence

   sequence s_slow_wake;
      sleeping && wake_ok && need_dly;
   endsequence

   a_cpu_stops: assert property (s_enter_sleep |=> !clk_en_o.cpu)
      else $error("CPU clock still enabled after sleep entry");
   a_ref_kept: assert property (s_enter_sleep |=>
      clk_en_o.ref_osc == $past(clk_en_o.ref_osc))
      else $error("sleep entry changed the reference oscillator");
   a_ref_either: assert property (clk_en_o.ref_osc ==
      (state_reg.clock_speed_control[9] | state_reg.clock_speed_control[8]))
      else $error("reference enable does not follow bits 8 and 9");
   a_osc_select: assert property ((clk_en_o.rc_trimmed_oscillator | clk_en_o.crystal_reference_oscillator) |->
      (clk_en_o.rc_trimmed_oscillator ? rto_bit && !xtal_s : cro_bit && xtal_s))
      else $error("oscillator enable taken from the wrong bit");
   a_pll_ref: assert property (clk_en_o.pll_ref |->
      ref_en && !state_reg.clock_speed_control[10])
      else $error("PLL regulating without reference or with idle set");
   a_light_mclk: assert property ((sleeping && !idle && ref_en) |->
      clk_en_o.mclk && clk_en_o.pll)
      else $error("master clock stopped in light sleep");
   a_idle_stop: assert property ((sleeping && idle) |->
      !clk_en_o.mclk && !clk_en_o.pll && !clk_en_o.cpu)
      else $error("clocks running in sleep with idle set");
   a_timer_deep: assert property ((sleeping && idle && !ref_en) |->
      clk_en_o.timer == 2'b00)
      else $error("timer clock running in deep sleep");
   a_arm_async: assert property (async_resp_o ==
      (state_reg.st == ST_SLEEP && state_reg.interrupt_general_control[14]))
      else $error("asynchronous response not tied to arm in sleep");
   a_no_wake: assert property ((sleeping && idle && !arm &&
      !(wr && idx == `SLPC_IDX_IGC) && !(wr && idx == `SLPC_IDX_CSC))
      |=> sleeping)
      else $error("woke with idle set and arm clear");
   a_slow_hold: assert property (s_slow_wake |=>
      (core_hold_o && dly_busy) [*2])
      else $error("core released before oscillator restart");
   a_reset_run: assert property ($past(sys_rst_i) |->
      state_reg.st == ST_RUN && !sleeping_o)
      else $error("reset did not end sleep");

endmodule : slpc_top
`default_nettype wire

// ===== verif/sleep_mode_clock_gating_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "slpc_params.svh"
`define CHK(g, e) begin n_tests++; \
   if ((g) !== (e)) begin bad_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sleep_mode_clock_gating_tb_top;
   import slpc_pkg::*;
   // ***************************************************************
   // Bench setup
   // ***************************************************************
   localparam int RTO_N = 5;
   localparam int CRO_N = 9;
   localparam logic [11:0] A_DAC = 12'({`SLPC_IDX_DAC, 2'b00});
   localparam logic [11:0] A_IGC = 12'({`SLPC_IDX_IGC, 2'b00});
   localparam logic [11:0] A_CSC = 12'({`SLPC_IDX_CSC, 2'b00});
   localparam logic [11:0] A_STS = 12'({`SLPC_IDX_IRQ_STS, 2'b00});
   localparam logic [11:0] A_MSK = 12'({`SLPC_IDX_IRQ_MSK, 2'b00});
   localparam logic [11:0] A_ST = 12'({`SLPC_IDX_STATE, 2'b00});
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   slpc_apb_req_s req = '0;
   logic sleep_req = 1'b0;
   logic osc_crystal = 1'b0;
   logic [1:0] timer_uf = 2'b00;
   logic [11:0] port_evt = 12'h000;
   logic [1:0] timer_en = 2'b11;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   slpc_clk_en_s clk_en_o;
   logic [7:0] pll_mult_o;
   logic async_resp_o;
   logic core_hold_o;
   logic sleeping_o;
   logic [13:0] wake_src_o;
   logic wake_pulse_o;
   logic irq_o;
   int bad_count = 0;
   int n_tests = 0;
   int c;

   always #50 clk_sys_i = ~clk_sys_i;

   slpc_top #(.RTO_START_CYC(RTO_N), .CRO_START_CYC(CRO_N)) u_dut (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .apb_i(req),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .sleep_req_i(sleep_req), .osc_crystal_i(osc_crystal),
      .timer_en_i(timer_en), .timer_src_ref_i(2'b01),
      .timer_uf_i(timer_uf), .port_evt_i(port_evt),
      .clk_en_o(clk_en_o), .pll_mult_o(pll_mult_o),
      .async_resp_o(async_resp_o), .core_hold_o(core_hold_o),
      .sleeping_o(sleeping_o), .wake_src_o(wake_src_o),
      .wake_pulse_o(wake_pulse_o), .irq_o(irq_o)
   );

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : tick

   // Read data is checked only on reads; error flag always
   task automatic acc(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, input logic [31:0] exp_rd,
                      input logic exp_err);
      @(posedge clk_sys_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk_sys_i);
      req.penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk_sys_i);
      end while (pready_o !== 1'b1);
      if (!wr) `CHK(prdata_o, exp_rd)
      `CHK(pslverr_o, exp_err)
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      #1;
   endtask : acc

   // Counts cycles of restart hold until it lets go
   task automatic hold_cnt(output int n);
      int i;
      n = 0;
      for (i = 0; i < 60; i++) begin
         if (core_hold_o === 1'b1) n++;
         else if (n > 0) break;
         tick(1);
      end
   endtask : hold_cnt

   task automatic go_sleep();
      @(posedge clk_sys_i);
      sleep_req <= 1'b1;
      @(posedge clk_sys_i);
      sleep_req <= 1'b0;
      #1;
   endtask : go_sleep

   // Holds the event until the wake pulse; counts restart cycles
   task automatic wake(input logic [11:0] p, input logic [1:0] t,
                       output int n);
      int i;
      n = 0;
      @(posedge clk_sys_i);
      port_evt <= p;
      timer_uf <= t;
      for (i = 0; i < 80; i++) begin
         tick(1);
         if (sleeping_o === 1'b0 && core_hold_o === 1'b1) n++;
         if (wake_pulse_o === 1'b1) break;
      end
      `CHK(wake_pulse_o, 1'b1)
      @(posedge clk_sys_i);
      port_evt <= 12'h000;
      timer_uf <= 2'b00;
      #1;
   endtask : wake

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, bad_count);
   endtask : end_test

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      tick(3);
      acc(0, A_CSC, 0, 32'h0, 1'b0);
      acc(0, A_IGC, 0, 32'h0, 1'b0);
      acc(0, A_DAC, 0, 32'h0, 1'b0);
      acc(0, A_ST, 0, 32'h0, 1'b0);
      acc(0, 12'h140, 0, 32'h0, 1'b1);
      acc(1, A_CSC + 12'h001, 32'h0400, 32'h0, 1'b1);
      acc(1, A_ST, 32'hff, 32'h0, 1'b0);
      acc(0, A_ST, 0, 32'h0, 1'b0);
      acc(1, A_DAC, 32'h0004, 32'h0, 1'b0);
      acc(0, A_DAC, 0, 32'h4, 1'b0);
      `CHK(clk_en_o.pdm, 1'b1)
      acc(1, A_DAC, 32'h0, 32'h0, 1'b0);
      end_test("registers");
      // RC source on bit 8, crystal source on bit 9
      acc(1, A_CSC, 32'h0100, 32'h0, 1'b0);
      hold_cnt(c);
      `CHK(c, RTO_N)
      `CHK(clk_en_o.rc_trimmed_oscillator, 1'b1)
      `CHK(clk_en_o.ref_osc, 1'b1)
      acc(1, A_CSC, 32'h0, 32'h0, 1'b0);
      `CHK(clk_en_o.ref_osc, 1'b0)
      @(posedge clk_sys_i);
      osc_crystal <= 1'b1;
      tick(4);
      acc(1, A_CSC, 32'h0200, 32'h0, 1'b0);
      hold_cnt(c);
      `CHK(c, CRO_N)
      `CHK(clk_en_o.crystal_reference_oscillator, 1'b1)
      `CHK(clk_en_o.rc_trimmed_oscillator, 1'b0)
      acc(0, A_ST, 0, 32'h18, 1'b0);
      acc(1, A_CSC, 32'h0300, 32'h0, 1'b0);
      `CHK(clk_en_o.ref_osc, 1'b1)
      acc(1, A_CSC, 32'h0, 32'h0, 1'b0);
      @(posedge clk_sys_i);
      osc_crystal <= 1'b0;
      tick(4);
      end_test("oscillator");
      // Light sleep: idle 0, reference on, arm 0
      acc(1, A_CSC, 32'h015a, 32'h0, 1'b0);
      hold_cnt(c);
      acc(1, A_STS, 32'h7, 32'h0, 1'b0);
      go_sleep();
      `CHK(sleeping_o, 1'b1)
      `CHK(clk_en_o.cpu, 1'b0)
      `CHK(clk_en_o.pll, 1'b1)
      `CHK(clk_en_o.mclk, 1'b1)
      `CHK(clk_en_o.pll_ref, 1'b1)
      `CHK(clk_en_o.ref_osc, 1'b1)
      `CHK(pll_mult_o, 8'h5a)
      `CHK(async_resp_o, 1'b0)
      `CHK(clk_en_o.timer, 2'b11)
      `CHK(clk_en_o.pdm, 1'b0)
      // A disabled timer gets no clock whatever its source
      @(posedge clk_sys_i);
      timer_en <= 2'b01;
      tick(1);
      `CHK(clk_en_o.timer, 2'b01)
      @(posedge clk_sys_i);
      timer_en <= 2'b11;
      wake(12'h004, 2'b00, c);
      `CHK(c, 0)
      `CHK(wake_src_o, 14'h0004)
      tick(1);
      `CHK(clk_en_o.cpu, 1'b1)
      // Interrupt status, mask and clear
      acc(0, A_STS, 0, 32'h5, 1'b0);
      `CHK(irq_o, 1'b0)
      acc(1, A_MSK, 32'h1, 32'h0, 1'b0);
      `CHK(irq_o, 1'b1)
      acc(1, A_STS, 32'h1, 32'h0, 1'b0);
      acc(0, A_STS, 0, 32'h4, 1'b0);
      `CHK(irq_o, 1'b0)
      acc(1, A_STS, 32'h4, 32'h0, 1'b0);
      end_test("light");
      // Mid sleep: idle 1, reference on, arm 1
      acc(1, A_CSC, 32'h0500, 32'h0, 1'b0);
      acc(1, A_IGC, 32'h4000, 32'h0, 1'b0);
      go_sleep();
      `CHK(clk_en_o.cpu, 1'b0)
      `CHK(clk_en_o.pll, 1'b0)
      `CHK(clk_en_o.mclk, 1'b0)
      `CHK(clk_en_o.ref_osc, 1'b1)
      `CHK(async_resp_o, 1'b1)
      `CHK(clk_en_o.timer, 2'b01)
      @(posedge clk_sys_i);
      timer_uf <= 2'b10;
      tick(8);
      `CHK(sleeping_o, 1'b1)
      @(posedge clk_sys_i);
      timer_uf <= 2'b00;
      tick(2);
      wake(12'h000, 2'b01, c);
      `CHK(c, RTO_N + 1)
      `CHK(wake_src_o, 14'h1000)
      acc(0, A_STS, 0, 32'h7, 1'b0);
      end_test("mid");
      // Deep sleep: idle 1, reference off, arm 1
      acc(1, A_STS, 32'h7, 32'h0, 1'b0);
      acc(1, A_CSC, 32'h0400, 32'h0, 1'b0);
      go_sleep();
      `CHK(clk_en_o.ref_osc, 1'b0)
      `CHK(clk_en_o.timer, 2'b00)
      `CHK(async_resp_o, 1'b1)
      wake(12'h800, 2'b00, c);
      `CHK(c, RTO_N + 1)
      `CHK(wake_src_o, 14'h0800)
      end_test("deep");
      // Idle 1 with arm 0: only reset ends sleep
      acc(1, A_IGC, 32'h0, 32'h0, 1'b0);
      go_sleep();
      `CHK(async_resp_o, 1'b0)
      @(posedge clk_sys_i);
      port_evt <= 12'h001;
      tick(10);
      `CHK(sleeping_o, 1'b1)
      @(posedge clk_sys_i);
      port_evt <= 12'h000;
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      tick(1);
      `CHK(sleeping_o, 1'b0)
      `CHK(clk_en_o.cpu, 1'b1)
      acc(0, A_CSC, 0, 32'h0, 1'b0);
      end_test("reset wake");
      tally_and_finish();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      bad_count++;
      tally_and_finish();
   end
endmodule : sleep_mode_clock_gating_tb_top
`default_nettype wire
